// ### hdl/tap_pkg.sv
// Shared constants and types of the boundary-scan test access port
package tap_pkg;

    // ************************************************************
    // Instruction register
    // ************************************************************
    localparam int IR_WIDTH = 6;
    localparam logic [5:0] INSN_EXTEST = 6'h00;
    localparam logic [5:0] INSN_SAMPLE_PRELOAD = 6'h01;
    localparam logic [5:0] INSN_IDCODE = 6'h02;
    localparam logic [5:0] INSN_AC_EXTEST = 6'h03;
    localparam logic [5:0] INSN_BYPASS = 6'h3f;
    // Fixed pattern loaded into the instruction shifter in Capture-IR
    localparam logic [5:0] IR_CAPTURE_VALUE = 6'h01;
    // Instruction held after Test-Logic-Reset
    localparam logic [5:0] IR_RESET_VALUE = 6'h02;

    // ************************************************************
    // Data registers
    // ************************************************************
    localparam int ID_WIDTH = 32;
    // Arbitrary identification value; bit 0 must stay set
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0001;
    localparam logic BYPASS_CAPTURE_VALUE = 1'b0;
    localparam int OBSERVE_CELLS_DEFAULT = 16;
    localparam int CONTROL_CELLS_DEFAULT = 16;

    // ************************************************************
    // Controller states
    // ************************************************************
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_type;

endpackage

// ### hdl/boundary_cell_chain.sv
// Boundary-scan chain of observe cells (receive pins) and control cells (transmit pins)
`timescale 1ns/100ps
`default_nettype none
module boundary_cell_chain #(
    parameter int N_OBS = tap_pkg::OBSERVE_CELLS_DEFAULT,
    parameter int N_CTL = tap_pkg::CONTROL_CELLS_DEFAULT
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic update_i,
    input wire logic tdi_i,
    input wire logic extest_i,
    input wire logic ac_mode_i,
    input wire logic toggle_i,
    input wire logic [N_OBS-1:0] rx_pin_i,
    input wire logic [N_CTL-1:0] core_tx_i,
    output logic [N_CTL-1:0] tx_pin_o,
    output logic so_o
);

    localparam int LEN = N_OBS + N_CTL;

    typedef struct packed {
        logic [N_OBS-1:0] rx_m;
        logic [N_OBS-1:0] rx_s;
        logic [LEN-1:0] sr;
        logic [N_CTL-1:0] upd;
        logic [N_CTL-1:0] tx;
    } chain_state_type;

    chain_state_type s_q;
    chain_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.rx_m = rx_pin_i;
        s_d.rx_s = s_q.rx_m;
        if (capture_i)
        begin
            s_d.sr = {core_tx_i, s_q.rx_s};
        end
        else if (shift_i)
        begin
            s_d.sr = {tdi_i, s_q.sr[LEN-1:1]};
        end
        if (update_i)
        begin
            s_d.upd = s_q.sr[LEN-1:N_OBS];
        end
        if (extest_i)
        begin
            s_d.tx = s_q.upd ^ {N_CTL{ac_mode_i & toggle_i}};
        end
        else
        begin
            s_d.tx = core_tx_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tx_pin_o = s_q.tx;
    assign so_o = s_q.sr[0];

endmodule
`default_nettype wire

// ### hdl/boundary_scan_tap.sv
// Boundary-scan test access port: controller, instruction and data registers
//
// Operation
// - Sixteen-state controller, six-bit instruction register
// - Low reset pin forces Test-Logic-Reset
// - Sample mode-select and data at clock rise
// - Serial output changes at clock fall
// - Output enabled only in shift states
// - Next state follows sampled mode-select
// - Five ones on mode-select reset
// - Serial input feeds selected register
// - Boundary chain for DC pins
// - AC test mode toggles transmit outputs
// - Readable identification register
// - Observe cells receive, control cells transmit
// - Instruction takes effect at Update-IR
// - Data registers parallel, one selected
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_tap #(
    parameter int N_OBS = tap_pkg::OBSERVE_CELLS_DEFAULT,
    parameter int N_CTL = tap_pkg::CONTROL_CELLS_DEFAULT,
    parameter logic [31:0] ID_CODE = tap_pkg::ID_CODE_DEFAULT
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [N_OBS-1:0] rx_pin_i,
    input wire logic [N_CTL-1:0] core_tx_i,
    output logic [N_CTL-1:0] tx_pin_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic tck_m;
        logic tck_s;
        logic tck_p;
        logic tms_m;
        logic tms_s;
        logic tdi_m;
        logic tdi_s;
        logic trst_n_m;
        logic trst_n_s;
        tap_pkg::tap_state_type state;
        logic [tap_pkg::IR_WIDTH-1:0] ir_sr;
        logic [tap_pkg::IR_WIDTH-1:0] ir;
        logic bypass;
        logic [tap_pkg::ID_WIDTH-1:0] id_sr;
        logic tdo;
        logic tdo_oe;
        logic toggle;
    } tap_regs_type;

    tap_regs_type s_q;
    tap_regs_type s_d;

    logic tck_rise;
    logic tck_fall;
    logic sel_chain;
    logic sel_id;
    logic sel_bypass;
    logic extest_mode;
    logic ac_mode;
    logic chain_capture;
    logic chain_shift;
    logic chain_update;
    logic chain_so;
    logic dr_so;

    // ************************************************************
    // Controller transition graph
    // ************************************************************
    // standard state diagram
    function automatic tap_pkg::tap_state_type next_state(input tap_pkg::tap_state_type st, input logic tms);
        next_state = st;
        unique case (st)
            tap_pkg::TEST_LOGIC_RESET: next_state = tms ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::RUN_TEST_IDLE: next_state = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::SELECT_DR: next_state = tms ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
            tap_pkg::CAPTURE_DR: next_state = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::SHIFT_DR: next_state = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::EXIT1_DR: next_state = tms ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
            tap_pkg::PAUSE_DR: next_state = tms ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
            tap_pkg::EXIT2_DR: next_state = tms ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
            tap_pkg::UPDATE_DR: next_state = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::SELECT_IR: next_state = tms ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
            tap_pkg::CAPTURE_IR: next_state = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::SHIFT_IR: next_state = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::EXIT1_IR: next_state = tms ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
            tap_pkg::PAUSE_IR: next_state = tms ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
            tap_pkg::EXIT2_IR: next_state = tms ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
            tap_pkg::UPDATE_IR: next_state = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
        endcase
    endfunction

    // ************************************************************
    // Edge detection and register selection
    // ************************************************************
    // sample on rising edge
    assign tck_rise = s_q.tck_s & ~s_q.tck_p;
    assign tck_fall = ~s_q.tck_s & s_q.tck_p;

    always_comb
    begin
        sel_chain = 1'b0;
        sel_id = 1'b0;
        extest_mode = 1'b0;
        ac_mode = 1'b0;
        unique case (s_q.ir)
            tap_pkg::INSN_EXTEST:
            begin
                sel_chain = 1'b1;
                extest_mode = 1'b1;
            end
            tap_pkg::INSN_AC_EXTEST:
            begin
                sel_chain = 1'b1;
                extest_mode = 1'b1;
                ac_mode = 1'b1;
            end
            tap_pkg::INSN_SAMPLE_PRELOAD: sel_chain = 1'b1;
            tap_pkg::INSN_IDCODE: sel_id = 1'b1;
            default: sel_chain = 1'b0;
        endcase
    end

    assign sel_bypass = ~sel_chain & ~sel_id;

    assign chain_capture = tck_rise & sel_chain & (s_q.state == tap_pkg::CAPTURE_DR);
    assign chain_shift = tck_rise & sel_chain & (s_q.state == tap_pkg::SHIFT_DR);
    assign chain_update = tck_fall & sel_chain & (s_q.state == tap_pkg::UPDATE_DR);

    assign dr_so = sel_chain ? chain_so : (sel_id ? s_q.id_sr[0] : s_q.bypass);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.tck_m = tck_i;
        s_d.tck_s = s_q.tck_m;
        s_d.tck_p = s_q.tck_s;
        s_d.tms_m = tms_i;
        s_d.tms_s = s_q.tms_m;
        s_d.tdi_m = tdi_i;
        s_d.tdi_s = s_q.tdi_m;
        s_d.trst_n_m = trst_n_i;
        s_d.trst_n_s = s_q.trst_n_m;

        if (tck_rise)
        begin
            if (s_q.state == tap_pkg::CAPTURE_IR)
            begin
                s_d.ir_sr = tap_pkg::IR_CAPTURE_VALUE;
            end
            else if (s_q.state == tap_pkg::SHIFT_IR)
            begin
                s_d.ir_sr = {s_q.tdi_s, s_q.ir_sr[tap_pkg::IR_WIDTH-1:1]};
            end
            if (sel_bypass && s_q.state == tap_pkg::CAPTURE_DR)
            begin
                s_d.bypass = tap_pkg::BYPASS_CAPTURE_VALUE;
            end
            else if (sel_bypass && s_q.state == tap_pkg::SHIFT_DR)
            begin
                s_d.bypass = s_q.tdi_s;
            end
            if (sel_id && s_q.state == tap_pkg::CAPTURE_DR)
            begin
                s_d.id_sr = ID_CODE;
            end
            else if (sel_id && s_q.state == tap_pkg::SHIFT_DR)
            begin
                s_d.id_sr = {s_q.tdi_s, s_q.id_sr[tap_pkg::ID_WIDTH-1:1]};
            end
            s_d.state = next_state(s_q.state, s_q.tms_s);
        end

        if (tck_fall)
        begin
            if (s_q.state == tap_pkg::UPDATE_IR)
            begin
                s_d.ir = s_q.ir_sr;
            end
            s_d.tdo_oe = (s_q.state == tap_pkg::SHIFT_DR) || (s_q.state == tap_pkg::SHIFT_IR);
            s_d.tdo = (s_q.state == tap_pkg::SHIFT_IR) ? s_q.ir_sr[0] : dr_so;
            if (ac_mode && s_q.state == tap_pkg::RUN_TEST_IDLE)
            begin
                s_d.toggle = ~s_q.toggle;
            end
        end

        if (s_q.state == tap_pkg::TEST_LOGIC_RESET)
        begin
            s_d.ir = tap_pkg::IR_RESET_VALUE;
            s_d.toggle = 1'b0;
        end

        if (!s_q.trst_n_s)
        begin
            s_d.state = tap_pkg::TEST_LOGIC_RESET;
            s_d.ir = tap_pkg::IR_RESET_VALUE;
            s_d.tdo_oe = 1'b0;
            s_d.toggle = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
            s_q.trst_n_m <= 1'b1;
            s_q.trst_n_s <= 1'b1;
            s_q.state <= tap_pkg::TEST_LOGIC_RESET;
            s_q.ir <= tap_pkg::IR_RESET_VALUE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Boundary chain
    // ************************************************************
    boundary_cell_chain #(
        .N_OBS(N_OBS),
        .N_CTL(N_CTL)
    ) u_chain (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .capture_i(chain_capture),
        .shift_i(chain_shift),
        .update_i(chain_update),
        .tdi_i(s_q.tdi_s),
        .extest_i(extest_mode),
        .ac_mode_i(ac_mode),
        .toggle_i(s_q.toggle),
        .rx_pin_i(rx_pin_i),
        .core_tx_i(core_tx_i),
        .tx_pin_o(tx_pin_o),
        .so_o(chain_so)
    );

    assign tdo_o = s_q.tdo;
    assign tdo_oe_o = s_q.tdo_oe;

endmodule
`default_nettype wire

// ### verification/tap_tester.sv
// Board tester model driving the test pins
`timescale 1ns/100ps
`default_nettype none
module tap_tester (
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o
);
    // ****************************************
    // Pin sequencing
    // ****************************************
    // Clock stands low between frames, pulled-up lines idle high
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_n_o = 1'b1;
    end
    // Change at fall, stable over rise
    task automatic cycle(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_o = tms;
        tdi_o = tdi;
        #200 tck_o = 1'b1;
        #200 tdo = tdo_i;
        oe = tdo_oe_i;
        tck_o = 1'b0;
    endtask
    task automatic to_idle();
        logic d;
        logic e;
        repeat (5) cycle(1'b1, 1'b1, d, e);
        cycle(1'b0, 1'b1, d, e);
        tms_o = 1'b1;
    endtask
    // Scan n bits through IR or DR, from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout,
                        output logic oe_ok);
        logic d;
        logic e;
        dout = '0;
        cycle(1'b1, 1'b1, d, e);
        if (ir)
        begin
            cycle(1'b1, 1'b1, d, e);
        end
        cycle(1'b0, 1'b1, d, e);
        cycle(1'b0, 1'b1, d, e);
        oe_ok = !e;
        for (int i = 0; i < n; i++)
        begin
            cycle(i == n - 1, din[i], dout[i], e);
            oe_ok = oe_ok & e;
        end
        cycle(1'b1, 1'b1, d, e);
        oe_ok = oe_ok & !e;
        cycle(1'b0, 1'b1, d, e);
        tms_o = 1'b1;
        tdi_o = 1'b1;
    endtask
    task automatic hard_reset();
        trst_n_o = 1'b0;
        #300 trst_n_o = 1'b1;
        #150;
    endtask
endmodule
`default_nettype wire

// ### verification/boundary_scan_tap_asserts.sv
// Assertions on the test access port pins
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_tap_asserts #(
    parameter int N_OBS = 16,
    parameter int N_CTL = 16,
    parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [N_OBS-1:0] rx_pin_i,
    input wire logic [N_CTL-1:0] core_tx_i,
    input wire logic [N_CTL-1:0] tx_pin_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence s_quiet;
        trst_n_i [*6];
    endsequence
    sequence s_after_fall;
        !$past(tck_i, 3) && $past(tck_i, 5);
    endsequence
    property p_oe_trst;
        !trst_n_i [*4] |=> !tdo_oe_o;
    endproperty
    property p_tdo_fall;
        s_quiet ##1 $changed(tdo_o) |-> s_after_fall;
    endproperty
    property p_oe_fall;
        s_quiet ##1 $changed(tdo_oe_o) |-> s_after_fall;
    endproperty
    property p_rst_quiet;
        $fell(srst_i) |-> tx_pin_o == '0 && !tdo_oe_o && !tdo_o;
    endproperty
    property p_rst_pass;
        $fell(srst_i) |=> tx_pin_o == $past(core_tx_i);
    endproperty
    property p_oe_hold;
        disable iff (srst_i || !trst_n_i) $rose(tdo_oe_o) |-> tdo_oe_o [*5];
    endproperty
    property p_still_oe;
        disable iff (srst_i || !trst_n_i) !tck_i [*8] |-> $stable(tdo_oe_o);
    endproperty
    property p_still_tdo;
        disable iff (srst_i || !trst_n_i) !tck_i [*8] |-> $stable(tdo_o);
    endproperty
    a_oe_trst: assert property (p_oe_trst) else $error("oe high after test reset");
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved away from clock fall");
    a_oe_fall: assert property (p_oe_fall) else $error("oe moved away from clock fall");
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not cleared by reset");
    a_rst_pass: assert property (p_rst_pass) else $error("tx not following core after reset");
    a_oe_hold: assert property (p_oe_hold) else $error("oe pulse too short");
    a_still_oe: assert property (p_still_oe) else $error("oe moved with clock stopped");
    a_still_tdo: assert property (p_still_tdo) else $error("tdo moved with clock stopped");
endmodule
bind boundary_scan_tap boundary_scan_tap_asserts #(.N_OBS(N_OBS), .N_CTL(N_CTL), .ID_CODE(ID_CODE)) u_asserts (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .trst_n_i(trst_n_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .rx_pin_i(rx_pin_i), .core_tx_i(core_tx_i), .tx_pin_o(tx_pin_o));
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench of the test access port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // Arbitrary identification value, bit 0 set
    localparam logic [31:0] ID_VAL = 32'h0000_0a5f;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_oe;
    wire tdo_pin;
    logic [15:0] rx_pin = 16'h3c96;
    logic [15:0] core_tx = 16'h00ff;
    logic [15:0] tx_pin;
    logic [31:0] got;
    logic ok;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    assign tdo_pin = tdo_oe ? tdo : 1'bz;
    always #25 clk_sys_i = ~clk_sys_i;
    boundary_scan_tap #(.N_OBS(16), .N_CTL(16), .ID_CODE(ID_VAL)) u_boundary_scan_tap (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .rx_pin_i(rx_pin), .core_tx_i(core_tx), .tx_pin_o(tx_pin));
    tap_tester u_tap_tester (.tdo_i(tdo_pin), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic run(input logic ir, input int n, input logic [31:0] din);
        u_tap_tester.scan(ir, n, din, got, ok);
        chk({31'h0, ok}, 32'h1, "oe window");
    endtask
    task automatic load_ir(input logic [5:0] code);
        run(1'b1, 6, {26'h0, code});
        chk(got, 32'h1, "ir capture");
    endtask
    task automatic tx_is(input logic [15:0] e);
        repeat (10) @(negedge clk_sys_i);
        chk({16'h0, tx_pin}, {16'h0, e}, "tx pins");
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_idcode();
        run(1'b0, 32, 32'h0);
        chk(got, ID_VAL, "idcode");
        $display("test idcode done");
    endtask
    task automatic t_bypass();
        logic [5:0] codes [2] = '{tap_pkg::INSN_BYPASS, 6'h2a};
        foreach (codes[i])
        begin
            load_ir(codes[i]);
            run(1'b0, 8, 32'h5a);
            chk(got, 32'hb4, "bypass");
        end
        $display("test bypass done");
    endtask
    task automatic t_extest();
        @(negedge clk_sys_i) core_tx = 16'h1234;
        load_ir(tap_pkg::INSN_SAMPLE_PRELOAD);
        run(1'b0, 32, 32'hc3a5_0000);
        chk(got, {16'h1234, 16'h3c96}, "chain capture");
        tx_is(16'h1234);
        load_ir(tap_pkg::INSN_EXTEST);
        tx_is(16'hc3a5);
        $display("test extest done");
    endtask
    task automatic t_ac();
        logic d;
        logic e;
        load_ir(tap_pkg::INSN_AC_EXTEST);
        // The fall in idle that ends the load inverts the latched drive once
        tx_is(16'h3c5a);
        u_tap_tester.cycle(1'b0, 1'b1, d, e);
        tx_is(16'hc3a5);
        $display("test ac done");
    endtask
    task automatic t_resets();
        u_tap_tester.to_idle();
        tx_is(16'h1234);
        run(1'b0, 32, 32'h0);
        chk(got, ID_VAL, "idcode after tms reset");
        load_ir(tap_pkg::INSN_EXTEST);
        u_tap_tester.hard_reset();
        tx_is(16'h1234);
        u_tap_tester.to_idle();
        run(1'b0, 32, 32'h0);
        chk(got, ID_VAL, "idcode after test reset");
        $display("test resets done");
    endtask
    // ****************************************
    // Sequence and timeout
    // ****************************************
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            $display("BAD %0t timeout", $time);
            finish_test();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i) srst_i = 1'b0;
        // Pin activity starts on a falling edge, away from the sampling edge
        repeat (4) @(negedge clk_sys_i);
        u_tap_tester.to_idle();
        t_idcode();
        t_bypass();
        t_extest();
        t_ac();
        t_resets();
        finish_test();
    end
endmodule
`default_nettype wire
